/* hw/dpc_regs.svh */
// Register offsets, field positions and reset values of the dual port pin control
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// Byte offsets within the block's window
`define DPC_OFS_WIDE_PINS     8'h00
`define DPC_OFS_WIDE_LATCH    8'h04
`define DPC_OFS_WIDE_DIR      8'h08
`define DPC_OFS_NARROW_PINS   8'h0c
`define DPC_OFS_NARROW_LATCH  8'h10
`define DPC_OFS_NARROW_DIR    8'h14
`define DPC_OFS_PWM_CTRL      8'h18
`define DPC_OFS_PIN_CFG       8'h1c

// Narrow direction register fields, then the input only bit of the narrow pin register
`define DPC_BIT_IBF           7
`define DPC_BIT_OBF           6
`define DPC_BIT_OVF           5
`define DPC_BIT_SLAVE_MODE    4
`define DPC_BIT_INPUT_ONLY    3

// PWM control mode field and own pin configuration fields
`define DPC_PWM_MODE_HI       7
`define DPC_PWM_MODE_LO       6
`define DPC_BIT_SHDN_TRI      3

// Reset values
`define DPC_RST_WIDE_DIR      8'hff
`define DPC_RST_NARROW_DIR    3'h7
`define DPC_RST_ANALOG        3'h7
`define DPC_RST_BYTE          8'h00

`endif

/* hw/dpc_pkg.sv */
// Types shared by the dual port pin control files
package dpc_pkg;

   typedef logic [7:0] dpc_byte_t;

   // PWM output modes, in the order of their two-bit codes
   typedef enum logic [1:0] {
      dpc_pwm_single,
      dpc_pwm_full_fwd,
      dpc_pwm_half,
      dpc_pwm_full_rev
   } dpc_pwm_mode_t;

endpackage : dpc_pkg

/* hw/dpc_sync.sv */
// Two flip-flop synchroniser for pin levels
module dpc_sync
   import dpc_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] stage1;

   // First stage feeds only the second, to keep metastability contained
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule : dpc_sync

/* hw/dpc_pin_cell.sv */
// Output driver selection for one pin
module dpc_pin_cell
   import dpc_pkg::*;
(
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Port function
   input  wire logic latch_bit,
   input  wire logic dir_bit,
   // Slave bus function
   input  wire logic slave_en,
   input  wire logic slave_drive,
   // PWM function
   input  wire logic pwm_own,
   input  wire logic pwm_bit,
   input  wire logic pwm_tri,
   // Pin driver
   output logic      pin_out,
   output logic      pin_oe_n
);

   // PWM first, then slave bus, then plain port; driver off at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b1;
      end else if (pwm_own && !dir_bit) begin
         pin_out  <= pwm_bit;
         pin_oe_n <= pwm_tri;
      end else if (slave_en) begin
         pin_out  <= latch_bit;
         pin_oe_n <= !slave_drive;
      end else begin
         pin_out  <= latch_bit;
         pin_oe_n <= dir_bit;
      end
   end

endmodule : dpc_pin_cell

/* hw/dpc_port_ctrl.sv */
// Dual port pin control: AHB-Lite registers, pin drivers and pin sampling
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`include "dpc_regs.svh"

module dpc_port_ctrl
   import dpc_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Wide port pins
   input  wire logic [7:0]  wide_port_in,
   output logic      [7:0]  wide_port_out,
   output logic      [7:0]  wide_port_oe_n,
   // Narrow port pins, bit 3 is the input only pin
   input  wire logic [3:0]  narrow_port_in,
   output logic      [2:0]  narrow_port_out,
   output logic      [2:0]  narrow_port_oe_n,
   // PWM unit
   input  wire logic        pwm_out_b,
   input  wire logic        pwm_out_c,
   input  wire logic        pwm_out_d,
   input  wire logic        pwm_shutdown,
   // Slave port handshake logic
   input  wire logic        slave_input_full,
   input  wire logic        slave_output_full,
   input  wire logic        slave_overflow_set,
   output logic             slave_mode_active,
   output logic             slave_read_enable,
   output logic             slave_write_enable,
   // Configuration and master clear
   input  wire logic        master_clear_enable_cfg,
   output logic             master_clear_req
);

   // Registers
   dpc_byte_t     wide_port_latch;
   dpc_byte_t     wide_port_direction;
   logic [2:0]    narrow_port_latch;
   logic [2:0]    narrow_dir;
   logic          slave_mode_select;
   logic          slave_input_overflow;
   dpc_byte_t     pwm_capture_control;
   logic [2:0]    analog_select;
   logic          shdn_tri_en;

   // Bus state
   logic          wr_pend;
   logic          rd_pend;
   logic [7:0]    bus_addr;
   logic [31:0]   rd_mux;
   logic          addr_take;

   // Pin side
   dpc_byte_t     wide_s;
   logic [3:0]    narrow_s;
   logic          master_clear_input_cfg_s;
   dpc_pwm_mode_t pwm_mode;
   logic          slave_active;
   logic          slave_drive;
   logic          pwm_tri;
   logic [7:0]    wide_pwm_own;
   logic [7:0]    wide_pwm_bits;
   dpc_byte_t     wide_dir_eff;
   logic [2:0]    narrow_dir_eff;

   // Pin levels cross into the clock domain before anyone reads them
   // synchronised pin sampling
   dpc_sync #(.W(8)) u_sync_wide (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (wide_port_in),
      .q       (wide_s)
   );

   dpc_sync #(.W(4)) u_sync_narrow (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (narrow_port_in),
      .q       (narrow_s)
   );

   // Configuration fuse is treated like a pin, caught after reset release
   dpc_sync #(.W(1)) u_sync_cfg (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (master_clear_enable_cfg),
      .q       (master_clear_input_cfg_s)
   );

   // Address phase accepted on a selected non-sequential or sequential transfer
   assign addr_take = hsel && htrans[1] && hready;

   // Bus control: writes zero wait, reads one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         bus_addr  <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend <= addr_take && hwrite;
         rd_pend <= addr_take && !hwrite;
         if (addr_take) begin
            bus_addr <= haddr[7:0];
         end
         hreadyout <= !(addr_take && !hwrite);
      end
   end

   // Read data loaded after the wait, so a preceding write is already seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend) begin
         hrdata <= rd_mux;
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (bus_addr == `DPC_OFS_WIDE_PINS) begin
         rd_mux[7:0] = wide_s;
      end else if (bus_addr == `DPC_OFS_WIDE_LATCH) begin
         rd_mux[7:0] = wide_port_latch;
      end else if (bus_addr == `DPC_OFS_WIDE_DIR) begin
         rd_mux[7:0] = wide_port_direction;
      end else if (bus_addr == `DPC_OFS_NARROW_PINS) begin
         rd_mux[2:0] = narrow_s[2:0] & ~analog_select & {3{LARGE_PKG}};
         // fourth pin is a port input only without master clear
         rd_mux[`DPC_BIT_INPUT_ONLY] = !master_clear_input_cfg_s && narrow_s[3];
      end else if (bus_addr == `DPC_OFS_NARROW_LATCH) begin
         rd_mux[2:0] = narrow_port_latch;
      end else if (bus_addr == `DPC_OFS_NARROW_DIR) begin
         // slave flags and mode above, bit 3 zero
         rd_mux[`DPC_BIT_IBF]        = slave_input_full;
         rd_mux[`DPC_BIT_OBF]        = slave_output_full;
         rd_mux[`DPC_BIT_OVF]        = slave_input_overflow;
         rd_mux[`DPC_BIT_SLAVE_MODE] = slave_mode_select;
         rd_mux[2:0]                 = narrow_dir;
      end else if (bus_addr == `DPC_OFS_PWM_CTRL) begin
         rd_mux[7:0] = pwm_capture_control;
      end else if (bus_addr == `DPC_OFS_PIN_CFG) begin
         rd_mux[2:0]              = analog_select;
         rd_mux[`DPC_BIT_SHDN_TRI] = shdn_tri_en;
      end
   end

   // Wide latch: written through the latch or the pin register
   // pin write lands in latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wide_port_latch <= `DPC_RST_BYTE;
      end else if (wr_pend && (bus_addr == `DPC_OFS_WIDE_PINS ||
                               bus_addr == `DPC_OFS_WIDE_LATCH)) begin
         wide_port_latch <= hwdata[7:0];
      end
   end

   // Wide direction, all inputs after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wide_port_direction <= `DPC_RST_WIDE_DIR;
      end else if (wr_pend && bus_addr == `DPC_OFS_WIDE_DIR) begin
         wide_port_direction <= hwdata[7:0];
      end
   end

   // Narrow latch, pin register writes alias onto it
   // latch is its own register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         narrow_port_latch <= 3'h0;
      end else if (wr_pend && (bus_addr == `DPC_OFS_NARROW_PINS ||
                               bus_addr == `DPC_OFS_NARROW_LATCH)) begin
         narrow_port_latch <= hwdata[2:0];
      end
   end

   // Narrow direction and slave mode select; the full flags are read only
   // slave mode select bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         narrow_dir        <= `DPC_RST_NARROW_DIR;
         slave_mode_select <= 1'b0;
      end else if (wr_pend && bus_addr == `DPC_OFS_NARROW_DIR) begin
         narrow_dir        <= hwdata[2:0];
         slave_mode_select <= hwdata[`DPC_BIT_SLAVE_MODE];
      end
   end

   // Overflow flag: hardware set wins over a software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slave_input_overflow <= 1'b0;
      end else if (slave_overflow_set) begin
         slave_input_overflow <= 1'b1;
      end else if (wr_pend && bus_addr == `DPC_OFS_NARROW_DIR) begin
         slave_input_overflow <= hwdata[`DPC_BIT_OVF];
      end
   end

   // PWM control shadow, only the mode field matters here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_capture_control <= `DPC_RST_BYTE;
      end else if (wr_pend && bus_addr == `DPC_OFS_PWM_CTRL) begin
         pwm_capture_control <= hwdata[7:0];
      end
   end

   // Analog selection and shutdown float enable
   // analog after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         analog_select <= `DPC_RST_ANALOG;
         shdn_tri_en   <= 1'b0;
      end else if (wr_pend && bus_addr == `DPC_OFS_PIN_CFG) begin
         analog_select <= hwdata[2:0];
         shdn_tri_en   <= hwdata[`DPC_BIT_SHDN_TRI];
      end
   end

   // PWM ownership of wide pins 5..7
   assign pwm_mode = dpc_pwm_mode_t'({pwm_capture_control[`DPC_PWM_MODE_HI],
                                      pwm_capture_control[`DPC_PWM_MODE_LO]});

   always_comb begin
      wide_pwm_own = 8'h00;
      wide_pwm_own[5] = (pwm_mode != dpc_pwm_single);
      wide_pwm_own[6] = (pwm_mode == dpc_pwm_full_fwd) || (pwm_mode == dpc_pwm_full_rev);
      wide_pwm_own[7] = wide_pwm_own[6];
   end

   assign wide_pwm_bits = {pwm_out_d, pwm_out_c, pwm_out_b, 5'h00};

   assign pwm_tri = shdn_tri_en && pwm_shutdown;

   // dual or quad outputs disable the slave port
   assign slave_active = slave_mode_select && (pwm_mode == dpc_pwm_single) && LARGE_PKG;

   // drive latch while host reads with chip select, both active low
   // strobes come from the host on narrow pins 0 and 2
   assign slave_drive = slave_active && !narrow_s[0] && !narrow_s[2];

   // small package keeps every driver off
   assign wide_dir_eff   = LARGE_PKG ? wide_port_direction : `DPC_RST_WIDE_DIR;
   assign narrow_dir_eff = LARGE_PKG ? narrow_dir : `DPC_RST_NARROW_DIR;

   // Wide port pin drivers
   // PWM before slave and port data
   for (genvar i = 0; i < 8; i++) begin : g_wide
      dpc_pin_cell u_cell (
         .hclk        (hclk),
         .hresetn     (hresetn),
         .latch_bit   (wide_port_latch[i]),
         .dir_bit     (wide_dir_eff[i]),
         .slave_en    (slave_active),
         .slave_drive (slave_drive),
         .pwm_own     (wide_pwm_own[i]),
         .pwm_bit     (wide_pwm_bits[i]),
         .pwm_tri     (pwm_tri),
         .pin_out     (wide_port_out[i]),
         .pin_oe_n    (wide_port_oe_n[i])
      );
   end

   // Narrow port drivers; analog selection is not an input here on purpose
   // three direction-controlled pins
   for (genvar j = 0; j < 3; j++) begin : g_narrow
      dpc_pin_cell u_cell (
         .hclk        (hclk),
         .hresetn     (hresetn),
         .latch_bit   (narrow_port_latch[j]),
         .dir_bit     (narrow_dir_eff[j]),
         .slave_en    (1'b0),
         .slave_drive (1'b0),
         .pwm_own     (1'b0),
         .pwm_bit     (1'b0),
         .pwm_tri     (1'b0),
         .pin_out     (narrow_port_out[j]),
         .pin_oe_n    (narrow_port_oe_n[j])
      );
   end

   // Slave status toward the handshake logic, strobes made active high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slave_mode_active  <= 1'b0;
         slave_read_enable  <= 1'b0;
         slave_write_enable <= 1'b0;
      end else begin
         slave_mode_active  <= slave_active;
         slave_read_enable  <= slave_drive;
         slave_write_enable <= slave_active && !narrow_s[1] && !narrow_s[2];
      end
   end

   // Master clear request, pin is active low
   // pin becomes master clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_clear_req <= 1'b0;
      end else begin
         master_clear_req <= master_clear_input_cfg_s && !narrow_s[3];
      end
   end

   // Checks
   // slave read drives latch
   slave_read_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      slave_drive |=> !wide_port_oe_n[0] && wide_port_out[0] == $past(wide_port_latch[0]))
      else $error("slave read did not drive latch");

   pwm_b_priority_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wide_pwm_own[5] && !wide_dir_eff[5] && !pwm_tri)
      |=> !wide_port_oe_n[5] && wide_port_out[5] == $past(pwm_out_b))
      else $error("PWM B lost pin 5");

   shutdown_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (pwm_tri && wide_pwm_own[7] && !wide_dir_eff[7]) |=> wide_port_oe_n[7])
      else $error("PWM D pin driven in shutdown");

   slave_dir_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (slave_active && !slave_drive) |=> wide_port_oe_n == 8'hff)
      else $error("wide pin driven outside slave read");

   analog_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_pend && bus_addr == `DPC_OFS_NARROW_PINS && analog_select[0]) |=> !hrdata[0])
      else $error("analog pin read nonzero");

   // direction rules the driver despite analog selection
   narrow_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (analog_select[1] && !narrow_dir_eff[1])
      |=> !narrow_port_oe_n[1] && narrow_port_out[1] == $past(narrow_port_latch[1]))
      else $error("narrow pin 1 not driven");

   // master clear follows pin after two synchroniser stages
   master_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (master_clear_input_cfg_s && !narrow_s[3]) |=> master_clear_req)
      else $error("master clear missed");

   // PWM dual or quad blocks slave port
   pwm_blocks_slave_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (pwm_mode != dpc_pwm_single) |=> !slave_mode_active)
      else $error("slave port active in PWM mode");

   // Read answer comes after one wait state
   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (addr_take && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   slave_read_c: cover property (@(posedge hclk) disable iff (!hresetn) slave_drive);
   pwm_shutdown_c: cover property (@(posedge hclk) disable iff (!hresetn)
      pwm_tri && wide_pwm_own[5]);
   master_clear_c: cover property (@(posedge hclk) disable iff (!hresetn) master_clear_req);

endmodule : dpc_port_ctrl

/* testbench/dpc_pin_partner.sv */
// Pin-side model: host strobes, external drivers and released lines
module dpc_pin_partner (
   // Clock
   input  wire logic       hclk,
   // Device pin drivers
   input  wire logic [7:0] wide_out,
   input  wire logic [7:0] wide_oe_n,
   input  wire logic [2:0] narrow_out,
   input  wire logic [2:0] narrow_oe_n,
   // Levels the outside world puts on the pins
   input  wire logic [7:0] ext_wide,
   input  wire logic       ext_wide_en,
   input  wire logic [3:0] ext_narrow,
   // Resolved pin levels
   output logic      [7:0] wide_in,
   output logic      [3:0] narrow_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic tog = 1'b0;

   // Undriven wide lines wander, so a stale value never reads back
   always_ff @(posedge hclk) begin
      tog <= ~tog;
   end

   // Device drive wins; otherwise the outside level or a toggling float
   assign wide_in = (~wide_oe_n & wide_out)
                  | (wide_oe_n & (ext_wide_en ? ext_wide : {8{tog}}));
   // host strobes driven on input pins
   assign narrow_in[2:0] = (~narrow_oe_n & narrow_out) | (narrow_oe_n & ext_narrow[2:0]);
   assign narrow_in[3]   = ext_narrow[3];
endmodule : dpc_pin_partner

/* testbench/dual_port_pin_control_tb_top.sv */
// Self-checking bench for the dual port pin control
module dual_port_pin_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic        hreadyout, hresp, slave_act, master_clear_input_req, rd_phase = 1'b0;
   logic [7:0]  wide_in, wide_out, wide_oe_n, ext_wide = '0, v, e, ex;
   logic [3:0]  narrow_in, ext_nar = 4'hf;
   logic [2:0]  narrow_out, narrow_oe_n, n, own;
   logic        ext_wide_en = 1'b0, pwm_b = 1'b0, pwm_c = 1'b0, pwm_d = 1'b0;
   logic        pwm_sd = 1'b0, in_full = 1'b0, out_full = 1'b0, ovf_set = 1'b0;
   logic        mce_cfg = 1'b0, rd_en, wr_en;
   logic [7:0]  ra [4] = '{8'h08, 8'h14, 8'h1c, 8'h04};
   logic [31:0] rv [4] = '{32'h0000_00ff, 32'h0000_0007, 32'h0000_0007, 32'h0000_0000};
   logic [31:0] exp_q [$];
   int          bad_count = 0, num_checks = 0, cycles = 0;

   always #2.5 hclk = ~hclk;

   dpc_port_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .wide_port_in(wide_in), .wide_port_out(wide_out), .wide_port_oe_n(wide_oe_n),
      .narrow_port_in(narrow_in), .narrow_port_out(narrow_out),
      .narrow_port_oe_n(narrow_oe_n), .pwm_out_b(pwm_b), .pwm_out_c(pwm_c),
      .pwm_out_d(pwm_d), .pwm_shutdown(pwm_sd), .slave_input_full(in_full),
      .slave_output_full(out_full), .slave_overflow_set(ovf_set),
      .slave_mode_active(slave_act), .slave_read_enable(rd_en), .slave_write_enable(wr_en),
      .master_clear_enable_cfg(mce_cfg), .master_clear_req(master_clear_input_req));

   dpc_pin_partner pins (.hclk(hclk), .wide_out(wide_out), .wide_oe_n(wide_oe_n),
      .narrow_out(narrow_out), .narrow_oe_n(narrow_oe_n), .ext_wide(ext_wide),
      .ext_wide_en(ext_wide_en), .ext_narrow(ext_nar), .wide_in(wide_in),
      .narrow_in(narrow_in));

   task automatic give_verdict();
      // A read whose answer never came is a failure too
      if (exp_q.size() != 0) begin
         bad_count++;
         $display("mismatch pending_reads expected 0 seen %0d", exp_q.size());
      end
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic chk_rd(input logic [31:0] exv, input logic [31:0] got);
      num_checks++;
      if (got !== exv) begin
         bad_count++;
         $display("mismatch hrdata expected %h seen %h", exv, got);
      end
   endtask : chk_rd

   task automatic chk_pin(input string nm, input logic [7:0] exv, input logic [7:0] got);
      num_checks++;
      if (got !== exv) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exv, got);
      end
   endtask : chk_pin

   // One single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0000_00, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_phase <= !wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_phase <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exv);
      exp_q.push_back(exv);
      bus(1'b0, a, 32'h0000_0000);
   endtask : rd

   // Outputs settle within a few edges of their cause
   task automatic settle();
      repeat (5) @(posedge hclk);
   endtask : settle

   // Read data taken at the edge that ends the data phase
   always @(posedge hclk) begin
      if (rd_phase && hreadyout === 1'b1 && exp_q.size() > 0) begin
         chk_rd(exp_q.pop_front(), hrdata);
      end
   end

   // Hang guard, far above the expected run length
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(65));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      v = 8'($urandom);
      wr(8'h00, {24'h0, v});
      wr(8'h08, 32'h0000_0000);
      settle();
      chk_pin("wide_out", v, wide_out);
      chk_pin("wide_oe_n", 8'h00, wide_oe_n);
      rd(8'h04, {24'h0, v});
      rd(8'h00, {24'h0, v});
      e = 8'($urandom);
      ext_wide <= e;
      ext_wide_en <= 1'b1;
      wr(8'h08, 32'h0000_00ff);
      settle();
      chk_pin("wide_oe_n", 8'hff, wide_oe_n);
      rd(8'h00, {24'h0, e});
      // Narrow drivers with analog still selected
      n = 3'($urandom);
      wr(8'h10, {29'h0, n});
      wr(8'h14, 32'h0000_0000);
      settle();
      chk_pin("narrow_out", {5'h0, n}, {5'h0, narrow_out});
      chk_pin("narrow_oe_n", 8'h00, {5'h0, narrow_oe_n});
      rd(8'h0c, 32'h0000_0008);
      wr(8'h1c, 32'h0000_0000);
      settle();
      rd(8'h0c, {28'h0, 1'b1, n});
      rd(8'h10, {29'h0, n});
      // Slave mode with direction bits set to output on the wide port
      wr(8'h08, 32'h0000_0000);
      in_full <= 1'b1;
      out_full <= 1'b1;
      wr(8'h14, 32'h0000_0017);
      ovf_set <= 1'b1;
      @(posedge hclk);
      ovf_set <= 1'b0;
      settle();
      chk_pin("slave_active", 8'h01, {7'h0, slave_act});
      chk_pin("wide_oe_n", 8'hff, wide_oe_n);
      rd(8'h14, 32'h0000_00f7);
      ext_nar <= 4'b1010;
      settle();
      chk_pin("wide_out", v, wide_out);
      chk_pin("wide_oe_n", 8'h00, wide_oe_n);
      chk_pin("slave_read_enable", 8'h01, {7'h0, rd_en});
      chk_pin("slave_write_enable", 8'h00, {7'h0, wr_en});
      // Host write with chip select: pins stay inputs
      ext_nar <= 4'b1001;
      settle();
      chk_pin("slave_write_enable", 8'h01, {7'h0, wr_en});
      chk_pin("slave_read_enable", 8'h00, {7'h0, rd_en});
      chk_pin("wide_oe_n", 8'hff, wide_oe_n);
      ext_nar <= 4'b1111;
      // Every multi-output mode takes its pins from the PWM unit
      pwm_b <= 1'b1;
      pwm_d <= 1'b1;
      for (int m = 1; m < 4; m++) begin
         wr(8'h18, {24'h0, 2'(m), 6'h00});
         settle();
         own = (m == 2) ? 3'b001 : 3'b111;
         ex = {(own & 3'b101) | (~own & v[7:5]), v[4:0]};
         chk_pin("wide_out", ex, wide_out);
         chk_pin("wide_oe_n", 8'h00, wide_oe_n);
         chk_pin("slave_active", 8'h00, {7'h0, slave_act});
      end
      wr(8'h1c, 32'h0000_0008);
      pwm_sd <= 1'b1;
      settle();
      chk_pin("wide_oe_n", 8'he0, wide_oe_n);
      mce_cfg <= 1'b1;
      ext_nar <= 4'b0111;
      settle();
      chk_pin("master_clear_input_req", 8'h01, {7'h0, master_clear_input_req});
      rd(8'h0c, 32'h0000_0007);
      ext_nar <= 4'b1111;
      settle();
      chk_pin("master_clear_input_req", 8'h00, {7'h0, master_clear_input_req});
      give_verdict();
   end
endmodule : dual_port_pin_control_tb_top
